// ---- bit_sync.sv ----
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,    // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic d,      // Asynchronous input.
  output logic q           // Synchronised level.
);
  logic meta_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : bit_sync

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] SLAVE = 7'h2a;
  localparam logic [7:0] FIRST = 8'h3c;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic stretch = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic scl_pull_n, sda_pull_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire logic scl = scl_oe_n & scl_pull_n;
  wire logic sda = sda_oe_n & sda_pull_n;
  int num_errors = 0;
  int compares = 0;

  always #20 clk = ~clk;

  two_wire_master_receiver u_two_wire_master_receiver (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n)
  );
  tw_slave_model #(.ADDR(SLAVE), .FIRST(FIRST)) u_tw_slave_model (
    .scl(scl), .sda(sda), .stretch(stretch), .scl_pull_n(scl_pull_n), .sda_pull_n(sda_pull_n)
  );

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic ctl(input logic [7:0] v);
    logic [1:0] r;
    wr(tw_pkg::OFS_CONTROL, v, r);
  endtask : ctl

  task automatic wait_code(input logic [7:0] code);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    while (d[tw_pkg::CTL_FLAG] !== 1'b1) rd(tw_pkg::OFS_CONTROL, d, r);
    check(32'(scl_oe_n), 32'h0, "clock line held");
    rd(tw_pkg::OFS_STATUS, d, r);
    check(d & 32'hf8, {24'h0, code}, "status code");
  endtask : wait_code

  task automatic t_registers;
    logic [31:0] d;
    logic [1:0] r;
    rd(tw_pkg::OFS_CONTROL, d, r);
    check(d, {24'h0, tw_pkg::CONTROL_RESET}, "control reset");
    rd(tw_pkg::OFS_DATA, d, r);
    check(d, {24'h0, tw_pkg::DATA_RESET}, "data reset");
    rd(tw_pkg::OFS_STATUS, d, r);
    check(d, {24'h0, tw_pkg::ST_NONE}, "status reset");
    wr(tw_pkg::OFS_STATUS, 8'h03, r);
    rd(tw_pkg::OFS_STATUS, d, r);
    check(d, 32'hfb, "prescaler stored");
    check(d & 32'hf8, {24'h0, tw_pkg::ST_NONE}, "masked status");
    ctl(8'h41);
    rd(tw_pkg::OFS_CONTROL, d, r);
    check(d, 32'h41, "control read back");
    ctl(8'h00);
    rd(8'h0c, d, r);
    check({d[29:0], r}, {30'h0, tw_pkg::RESP_SLVERR}, "unmapped read");
    wr(8'h0c, 8'h5a, r);
    check(32'(r), 32'(tw_pkg::RESP_SLVERR), "unmapped write");
  endtask : t_registers

  task automatic t_collision;
    logic [31:0] d;
    logic [1:0] r;
    wr(tw_pkg::OFS_DATA, 8'h55, r);
    rd(tw_pkg::OFS_DATA, d, r);
    check(d, {24'h0, tw_pkg::DATA_RESET}, "data write kept out");
    rd(tw_pkg::OFS_CONTROL, d, r);
    check(32'(d[tw_pkg::CTL_WC]), 32'h1, "collision bit set");
  endtask : t_collision

  task automatic t_receive;
    logic [31:0] d;
    logic [1:0] r;
    ctl(8'ha4);
    wait_code(tw_pkg::ST_START_SENT);
    wr(tw_pkg::OFS_DATA, {SLAVE, 1'b1}, r);
    rd(tw_pkg::OFS_CONTROL, d, r);
    check(32'(d[tw_pkg::CTL_WC]), 32'h0, "collision bit cleared");
    ctl(8'h84);
    wait_code(tw_pkg::ST_RADDR_ACK);
    stretch <= 1'b1;
    ctl(8'hc4);
    wait_code(tw_pkg::ST_RXDATA_ACK);
    rd(tw_pkg::OFS_DATA, d, r);
    check(d, {24'h0, FIRST}, "first byte");
    ctl(8'h84);
    wait_code(tw_pkg::ST_RXDATA_NACK);
    rd(tw_pkg::OFS_DATA, d, r);
    check(d, {24'h0, FIRST + 8'h11}, "last byte");
    stretch <= 1'b0;
    ctl(8'ha4);
    wait_code(tw_pkg::ST_RSTART_SENT);
  endtask : t_receive

  task automatic t_restart;
    logic [31:0] d;
    logic [1:0] r;
    wr(tw_pkg::OFS_DATA, {~SLAVE, 1'b1}, r);
    ctl(8'h84);
    wait_code(tw_pkg::ST_RADDR_NACK);
    ctl(8'ha4);
    wait_code(tw_pkg::ST_RSTART_SENT);
    ctl(8'hb4);
    wait_code(tw_pkg::ST_START_SENT);
    wr(tw_pkg::OFS_DATA, {SLAVE, 1'b0}, r);
    ctl(8'h84);
    wait_code(tw_pkg::ST_WADDR_ACK);
    ctl(8'h94);
    d = 32'h10;
    while (d[tw_pkg::CTL_STO] !== 1'b0) rd(tw_pkg::OFS_CONTROL, d, r);
    check(32'(d[tw_pkg::CTL_FLAG]), 32'h0, "no flag after stop");
    check(32'({scl_oe_n, sda_oe_n}), 32'h3, "lines released");
  endtask : t_restart

  initial begin
    // Reset falls at time zero so every flop holds its reset value at the first edge.
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_registers();
    t_collision();
    t_receive();
    t_restart();
    test_done();
  end

  // Five bus bytes with polling need well under a millisecond.
  initial begin
    #2000000;
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : testbench

// ---- tw_checker.sv ----
`timescale 1ns/1ps
module tw_checker (
  input wire logic clk, // System clock.
  input wire logic resetn, // Reset, active low.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic scl_o, // Clock line drive level.
  input wire logic scl_oe_n, // Clock line pull, active low.
  input wire logic sda_o, // Data line drive level.
  input wire logic sda_oe_n // Data line pull, active low.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  drive_low_a: assert property (!scl_o && !sda_o) else $error("line drive level not low");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response not on time");
  write_busy_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_awready ##1 s_axi_awready)
    else $error("address ready out of step");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    !s_axi_arready) else $error("read answer not on time");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not withdrawn");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // A START is the only fall of the data line while the master leaves the clock high.
  start_clock_a: assert property ($fell(sda_oe_n) && scl_oe_n |-> ##[1:300] !scl_oe_n)
    else $error("clock not driven after start");
  stop_idle_a: assert property ($rose(sda_oe_n) && scl_oe_n |=> scl_oe_n [*8])
    else $error("clock pulled right after stop");
  reset_idle_a: assert property (disable iff (1'b0) !resetn |-> scl_oe_n && sda_oe_n &&
    !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active in reset");
endmodule : tw_checker

bind two_wire_master_receiver tw_checker u_tw_checker (
  .clk(clk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
);

// ---- tw_pkg.sv ----
package tw_pkg;

  // Bus timing: one bit is four quarter periods, 100 kbit/s on the wire.
  localparam int CLK_FREQ_MHZ = 25;
  localparam int QTR_BIT_NS = 2500;
  localparam int QTR_CYC = (QTR_BIT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

  // Register byte offsets.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;

  // Control register field positions.
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WC = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [1:0] PRESC_RESET = 2'h0;

  // Status codes with the prescaler bits at zero.
  localparam logic [7:0] ST_NONE = 8'hf8;
  localparam logic [7:0] ST_START_SENT = 8'h08;
  localparam logic [7:0] ST_RSTART_SENT = 8'h10;
  localparam logic [7:0] ST_WADDR_ACK = 8'h18;
  localparam logic [7:0] ST_WADDR_NACK = 8'h20;
  localparam logic [7:0] ST_TXDATA_ACK = 8'h28;
  localparam logic [7:0] ST_TXDATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_RADDR_ACK = 8'h40;
  localparam logic [7:0] ST_RADDR_NACK = 8'h48;
  localparam logic [7:0] ST_RXDATA_ACK = 8'h50;
  localparam logic [7:0] ST_RXDATA_NACK = 8'h58;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_START = 6'h02,
    S_RSTART = 6'h04,
    S_BYTE = 6'h08,
    S_HOLD = 6'h10,
    S_STOP = 6'h20
  } state_t;

endpackage : tw_pkg

// ---- tw_slave_model.sv ----
`timescale 1ns/1ps
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] FIRST = 8'h3c
) (
  input wire logic scl, // Clock line level.
  input wire logic sda, // Data line level.
  input wire logic stretch, // Hold the clock low after each fall.
  output logic scl_pull_n, // Pulls the clock line low when low.
  output logic sda_pull_n // Pulls the data line low when low.
);
  logic [7:0] shreg;
  logic [7:0] tx;
  logic active;
  logic data_phase;
  int bitn;
  initial begin
    scl_pull_n = 1'b1;
    sda_pull_n = 1'b1;
    active = 1'b0;
    data_phase = 1'b0;
    bitn = 0;
    shreg = 8'h00;
    tx = FIRST;
  end
  always @(negedge sda) begin
    if (scl) begin
      active = 1'b1;
      data_phase = 1'b0;
      bitn = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) active = 1'b0;
  end
  always @(posedge scl) begin
    if (active) begin
      if (!data_phase && bitn < 8) shreg = {shreg[6:0], sda};
      // A released acknowledge from the master ends the burst.
      if (data_phase && bitn == 8 && sda) active = 1'b0;
      bitn++;
    end
  end
  always @(negedge scl) begin
    if (active) begin
      if (bitn == 8 && !data_phase) begin
        active = (shreg[7:1] == ADDR);
        sda_pull_n = !active;
      end else if (bitn == 9) begin
        tx = data_phase ? tx + 8'h11 : FIRST;
        active = data_phase || shreg[0];
        data_phase = 1'b1;
        bitn = 0;
        sda_pull_n = !active || tx[7];
      end else if (data_phase) begin
        sda_pull_n = (bitn == 8) || tx[7 - bitn];
      end
    end
  end
  // A slow slave stretches every low phase so the master must wait on the line.
  always @(negedge scl) begin
    if (stretch) begin
      scl_pull_n = 1'b0;
      #8000;
      scl_pull_n = 1'b1;
    end
  end
endmodule : tw_slave_model

// ---- two_wire_master_receiver.sv ----
// Function
// R1: Start request with flag cleared and enable set waits for a free bus, then starts.
// R2: After START the flag is set and status reads 0x08.
// R3: Writing one to the flag clears it; clearing lets the transfer continue.
// R4: Read address selects master receiver, write address selects master transmitter.
// R5: Software masks the prescaler bits before comparing status codes.
// R6: After read address and acknowledge, flag set with status 0x38, 0x40 or 0x48.
// R7: A received byte is readable in the data register when the flag sets.
// R8: Software clears ack enable before the last byte so it gets NACK.
// R9: Stop request with flag clear sends STOP on the bus.
// R10: Start request with flag clear during a transfer sends repeated START.
// R11: After repeated START (0x10) any address, either direction, without STOP.
// R12: At 0x08 the loaded address is sent and the acknowledge sampled.
// R13: At 0x10 the loaded address is sent; write address enters transmitter operation.
// R14: Arbitration lost gives 0x38, bus released; start one restarts when bus free.
// R15: At 0x40 or 0x50 next byte received, ACK if ack enable set at clear.
// R16: At 0x48 start/stop choose repeated START, STOP, or STOP then START.
// R17: At 0x58 byte read, then repeated START, STOP or STOP then START.
// R18: The stop request bit clears itself once STOP is on the bus.
// R19: Status 0x50 means a byte was received and ACK returned.
// R20: Data register write with flag low is discarded and sets write collision.
// R21: While the flag is set the clock line is held low; after arbitration loss (0x38) the code releases it.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module two_wire_master_receiver (
  input wire logic clk,                 // System clock, 25 MHz.
  input wire logic resetn,              // Asynchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr,  // Write address.
  input wire logic s_axi_awvalid,       // Write address valid.
  output logic s_axi_awready,           // Write address ready.
  input wire logic [31:0] s_axi_wdata,  // Write data.
  input wire logic [3:0] s_axi_wstrb,   // Write byte strobes.
  input wire logic s_axi_wvalid,        // Write data valid.
  output logic s_axi_wready,            // Write data ready.
  output logic [1:0] s_axi_bresp,       // Write response.
  output logic s_axi_bvalid,            // Write response valid.
  input wire logic s_axi_bready,        // Write response ready.
  input wire logic [7:0] s_axi_araddr,  // Read address.
  input wire logic s_axi_arvalid,       // Read address valid.
  output logic s_axi_arready,           // Read address ready.
  output logic [31:0] s_axi_rdata,      // Read data.
  output logic [1:0] s_axi_rresp,       // Read response.
  output logic s_axi_rvalid,            // Read data valid.
  input wire logic s_axi_rready,        // Read data ready.
  input wire logic scl_i,               // Clock line level.
  output logic scl_o,                   // Clock line drive level, always low.
  output logic scl_oe_n,                // Clock line pulled low when this is low.
  input wire logic sda_i,               // Data line level.
  output logic sda_o,                   // Data line drive level, always low.
  output logic sda_oe_n                 // Data line pulled low when this is low.
);
  tw_pkg::state_t state_r, state_nxt;
  logic [5:0] qcnt_r;
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
  logic tx_r, tx_nxt, addr_r, addr_nxt, rd_r, rd_nxt, rep_r, rep_nxt;
  logic ack_lat_r, ack_lat_nxt, ackbit_r, ackbit_nxt;
  logic flag_set, data_set, sto_clr;
  logic [7:0] code_set;
  logic flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, ie_r;
  logic [4:0] code_r;
  logic [1:0] presc_r;
  logic [7:0] data_r;
  logic scl_s, sda_s, sda_d_r, busy_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r, wdat_r;
  logic wstrb0_r;
  logic drive_lvl_r;

  bit_sync #(.RESET_VAL(1'b1)) u_scl_sync (
    .clk(clk),
    .resetn(resetn),
    .d(scl_i),
    .q(scl_s)
  );

  bit_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .clk(clk),
    .resetn(resetn),
    .d(sda_i),
    .q(sda_s)
  );

  wire tick = (qcnt_r == tw_pkg::QTR_LAST);
  // A slave may stretch the clock, so the high phase waits for the line to rise.
  wire step = tick && !((phase_r == 2'd2) && !scl_s);
  wire start_det = scl_s && sda_d_r && !sda_s;
  wire stop_det = scl_s && !sda_d_r && sda_s;
  wire bus_free = !busy_r && scl_s && sda_s;
  wire [7:0] code_full = {code_r, 3'h0};
  wire last_bit = (bitcnt_r == 4'd8);
  wire lost_chk = tx_r ? !last_bit : last_bit;

  wire at_addr = (code_full == tw_pkg::ST_START_SENT) || (code_full == tw_pkg::ST_RSTART_SENT);
  wire at_tx = (code_full == tw_pkg::ST_WADDR_ACK) || (code_full == tw_pkg::ST_WADDR_NACK)
             || (code_full == tw_pkg::ST_TXDATA_ACK) || (code_full == tw_pkg::ST_TXDATA_NACK);
  wire at_rx = (code_full == tw_pkg::ST_RADDR_ACK) || (code_full == tw_pkg::ST_RXDATA_ACK);
  wire [7:0] addr_code = rd_r ? (ackbit_r ? tw_pkg::ST_RADDR_NACK : tw_pkg::ST_RADDR_ACK)
                              : (ackbit_r ? tw_pkg::ST_WADDR_NACK : tw_pkg::ST_WADDR_ACK);
  wire [7:0] txd_code = ackbit_r ? tw_pkg::ST_TXDATA_NACK : tw_pkg::ST_TXDATA_ACK;
  wire [7:0] rxd_code = ack_lat_r ? tw_pkg::ST_RXDATA_ACK : tw_pkg::ST_RXDATA_NACK;

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    rep_nxt = rep_r;
    ack_lat_nxt = ack_lat_r;
    ackbit_nxt = ackbit_r;
    flag_set = 1'b0;
    data_set = 1'b0;
    sto_clr = 1'b0;
    code_set = code_full;
    if (!en_r) begin
      state_nxt = tw_pkg::S_IDLE;
      phase_nxt = 2'd0;
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      rep_nxt = 1'b0;
    end else begin
      case (state_r)
        tw_pkg::S_IDLE: begin
          scl_low_nxt = 1'b0;
          sda_low_nxt = 1'b0;
          rep_nxt = 1'b0;
          if (sta_r && !flag_r && bus_free && tick) begin // R1 R14
            state_nxt = tw_pkg::S_START;
            phase_nxt = 2'd0;
          end
        end
        tw_pkg::S_START: begin
          if (step) begin
            phase_nxt = phase_r + 2'd1;
            if (phase_r == 2'd1) begin
              sda_low_nxt = 1'b1;
            end
            if (phase_r == 2'd3) begin
              scl_low_nxt = 1'b1;
              flag_set = 1'b1;
              code_set = rep_r ? tw_pkg::ST_RSTART_SENT : tw_pkg::ST_START_SENT; // R2 R11
              state_nxt = tw_pkg::S_HOLD;
            end
          end
        end
        tw_pkg::S_HOLD: begin
          scl_low_nxt = 1'b1; // R21
          if (!flag_r) begin // R3
            phase_nxt = 2'd0;
            bitcnt_nxt = 4'd0;
            if (sto_r) begin
              state_nxt = tw_pkg::S_STOP; // R9 R16 R17
            end else if (sta_r) begin
              state_nxt = tw_pkg::S_RSTART; // R10 R16 R17
            end else if (at_addr) begin
              state_nxt = tw_pkg::S_BYTE; // R12 R13 R11
              tx_nxt = 1'b1;
              addr_nxt = 1'b1;
              shift_nxt = data_r;
              rd_nxt = data_r[0];
            end else if (at_tx) begin
              state_nxt = tw_pkg::S_BYTE; // R13
              tx_nxt = 1'b1;
              addr_nxt = 1'b0;
              shift_nxt = data_r;
            end else if (at_rx) begin
              state_nxt = tw_pkg::S_BYTE; // R15
              tx_nxt = 1'b0;
              addr_nxt = 1'b0;
              ack_lat_nxt = ack_en_r;
            end
          end
        end
        tw_pkg::S_RSTART: begin
          if (step) begin
            phase_nxt = phase_r + 2'd1;
            if (phase_r == 2'd0) begin
              sda_low_nxt = 1'b0;
            end
            if (phase_r == 2'd1) begin
              scl_low_nxt = 1'b0;
            end
            if (phase_r == 2'd3) begin
              rep_nxt = 1'b1; // R10
              state_nxt = tw_pkg::S_START;
            end
          end
        end
        tw_pkg::S_STOP: begin
          if (step) begin
            phase_nxt = phase_r + 2'd1;
            if (phase_r == 2'd0) begin
              sda_low_nxt = 1'b1;
            end
            if (phase_r == 2'd1) begin
              scl_low_nxt = 1'b0;
            end
            if (phase_r == 2'd2) begin
              sda_low_nxt = 1'b0; // R9
            end
            if (phase_r == 2'd3) begin
              // A start request still pending runs the START once the bus is free.
              sto_clr = 1'b1; // R18
              state_nxt = tw_pkg::S_IDLE;
            end
          end
        end
        tw_pkg::S_BYTE: begin
          if (step) begin
            phase_nxt = phase_r + 2'd1;
            case (phase_r)
              2'd0: begin
                sda_low_nxt = last_bit ? (!tx_r && ack_lat_r) : (tx_r && !shift_r[7]); // R15
              end
              2'd1: begin
                scl_low_nxt = 1'b0;
              end
              2'd2: begin
                if (lost_chk && !sda_low_r && !sda_s) begin
                  state_nxt = tw_pkg::S_IDLE; // R14
                  scl_low_nxt = 1'b0;
                  sda_low_nxt = 1'b0;
                  flag_set = 1'b1;
                  code_set = tw_pkg::ST_ARB_LOST;
                end else if (last_bit) begin
                  ackbit_nxt = sda_s;
                end else if (!tx_r) begin
                  shift_nxt = {shift_r[6:0], sda_s};
                end
              end
              default: begin
                scl_low_nxt = 1'b1;
                if (last_bit) begin
                  state_nxt = tw_pkg::S_HOLD;
                  flag_set = 1'b1;
                  if (addr_r) begin
                    code_set = addr_code; // R4 R6
                  end else if (tx_r) begin
                    code_set = txd_code;
                  end else begin
                    data_set = 1'b1; // R7
                    code_set = rxd_code; // R19
                  end
                end else begin
                  bitcnt_nxt = bitcnt_r + 4'd1;
                  if (tx_r) begin
                    shift_nxt = {shift_r[6:0], 1'b0};
                  end
                end
              end
            endcase
          end
        end
        default: begin
          state_nxt = tw_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= tw_pkg::S_IDLE;
      qcnt_r <= 6'h00;
      phase_r <= 2'h0;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      {scl_low_r, sda_low_r, tx_r, addr_r, rd_r, rep_r, ack_lat_r, ackbit_r} <= 8'h00;
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
      drive_lvl_r <= 1'b0;
      {scl_oe_n, sda_oe_n} <= 2'h3;
    end else begin
      state_r <= state_nxt;
      qcnt_r <= tick ? 6'h00 : qcnt_r + 6'h01;
      phase_r <= phase_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      {scl_low_r, sda_low_r, tx_r, addr_r} <= {scl_low_nxt, sda_low_nxt, tx_nxt, addr_nxt};
      {rd_r, rep_r, ack_lat_r, ackbit_r} <= {rd_nxt, rep_nxt, ack_lat_nxt, ackbit_nxt};
      sda_d_r <= sda_s;
      busy_r <= start_det | (busy_r & ~stop_det);
      drive_lvl_r <= 1'b0;
      {scl_oe_n, sda_oe_n} <= {~scl_low_nxt, ~sda_low_nxt};
    end
  end

  assign scl_o = drive_lvl_r;
  assign sda_o = drive_lvl_r;

  // Register slave: one write and one read in flight, address and data in any order.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire aw_hold_nxt = (aw_hold_r && !do_wr) || aw_take;
  wire w_hold_nxt = (w_hold_r && !do_wr) || w_take;
  wire wr_ctl = do_wr && wstrb0_r && (awaddr_r == tw_pkg::OFS_CONTROL);
  wire wr_sts = do_wr && wstrb0_r && (awaddr_r == tw_pkg::OFS_STATUS);
  wire wr_dat = do_wr && wstrb0_r && (awaddr_r == tw_pkg::OFS_DATA);
  wire wr_hit = (awaddr_r == tw_pkg::OFS_CONTROL) || (awaddr_r == tw_pkg::OFS_STATUS)
              || (awaddr_r == tw_pkg::OFS_DATA);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_ctl = (s_axi_araddr == tw_pkg::OFS_CONTROL);
  wire rd_sts = (s_axi_araddr == tw_pkg::OFS_STATUS);
  wire rd_dat = (s_axi_araddr == tw_pkg::OFS_DATA);
  wire [7:0] ctl_view = {flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
  wire [7:0] sts_view = {code_r, 1'b0, presc_r}; // R5
  wire [7:0] rd_mux = rd_ctl ? ctl_view : (rd_sts ? sts_view : (rd_dat ? data_r : 8'h00));
  wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {aw_hold_r, w_hold_r, wstrb0_r} <= 3'h0;
      awaddr_r <= 8'h00;
      wdat_r <= 8'h00;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tw_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tw_pkg::RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      s_axi_awready <= !aw_hold_nxt;
      s_axi_wready <= !w_hold_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdat_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? tw_pkg::RESP_OKAY : tw_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_rvalid <= rvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= {24'h00_0000, rd_mux};
        s_axi_rresp <= (rd_ctl || rd_sts || rd_dat) ? tw_pkg::RESP_OKAY : tw_pkg::RESP_SLVERR;
      end
    end
  end

  // Hardware setting the flag wins over a clearing write in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, ie_r} <= 7'h00;
      code_r <= tw_pkg::ST_NONE[7:3];
      presc_r <= tw_pkg::PRESC_RESET;
      data_r <= tw_pkg::DATA_RESET;
    end else begin
      flag_r <= flag_set | (flag_r & ~(wr_ctl & wdat_r[tw_pkg::CTL_FLAG])); // R3
      if (wr_ctl) begin
        ack_en_r <= wdat_r[tw_pkg::CTL_ACK];
        sta_r <= wdat_r[tw_pkg::CTL_STA];
        en_r <= wdat_r[tw_pkg::CTL_EN];
        ie_r <= wdat_r[tw_pkg::CTL_IE];
      end
      sto_r <= wr_ctl ? wdat_r[tw_pkg::CTL_STO] : (sto_r & ~sto_clr); // R18
      if (flag_set) begin
        code_r <= code_set[7:3];
      end
      if (wr_sts) begin
        presc_r <= wdat_r[1:0];
      end
      if (wr_dat) begin
        wc_r <= !flag_r; // R20
      end
      if (data_set) begin
        data_r <= shift_r; // R7
      end else if (wr_dat && flag_r) begin
        data_r <= wdat_r; // R20
      end
    end
  end
endmodule : two_wire_master_receiver
